// [rtl/mst_consts.svh]
`ifndef MST_CONSTS_SVH
`define MST_CONSTS_SVH

// Register offsets on the configuration port
`define MST_OFS_DEMOD_FILTER_CONFIG        7'h10
`define MST_OFS_RATE_FORMAT_CRYSTAL_CONFIG 7'h11
`define MST_OFS_IMPEDANCE_TUNE_CAPS        7'h12
`define MST_OFS_SYNTH_RESET_CTRL           7'h13
`define MST_OFS_DIVIDER_IF_TEST_CTRL       7'h1c
`define MST_OFS_PUMP_PROBE_FORCE           7'h40
`define MST_OFS_PUMP_BLOCK_OSC_FORCE       7'h41
`define MST_OFS_LOOP_BANDWIDTH_SETTING     7'h42
`define MST_OFS_LOOP_OPEN_DAC_FORCE        7'h43
`define MST_OFS_PUMP_CURRENT_READBACK      7'h44
`define MST_OFS_TUNE_DAC_READBACK          7'h45
`define MST_OFS_OSC_ARRAY_READBACK         7'h46

// Storage index of each writable register
`define MST_NUM_RW    9
`define MST_IDX_DFC   4'h0
`define MST_IDX_RFC   4'h1
`define MST_IDX_ITC   4'h2
`define MST_IDX_SRC   4'h3
`define MST_IDX_DIT   4'h4
`define MST_IDX_PPF   4'h5
`define MST_IDX_PBO   4'h6
`define MST_IDX_LBS   4'h7
`define MST_IDX_LOD   4'h8
`define MST_IDX_NONE  4'hf

// Reset values
`define MST_RST_DFC   8'h67
`define MST_RST_RFC   8'h24
`define MST_RST_ITC   8'h00
`define MST_RST_SRC   8'h01
`define MST_RST_DIT   8'h00
`define MST_RST_PPF   8'h10
`define MST_RST_PBO   8'h08
`define MST_RST_LBS   8'h25
`define MST_RST_LOD   8'h04

// Writable bits; unused and reserved bits stay zero
`define MST_MSK_DFC   8'hff
`define MST_MSK_RFC   8'h7f
`define MST_MSK_ITC   8'hff
`define MST_MSK_SRC   8'h01
`define MST_MSK_DIT   8'hfc
`define MST_MSK_PPF   8'hff
`define MST_MSK_PBO   8'h3f
`define MST_MSK_LBS   8'h3f
`define MST_MSK_LOD   8'h1f

// Field positions
`define MST_F_VIOL_LIMIT      7:5
`define MST_F_AVG_LOCK_CTRL   4
`define MST_F_AVG_LOCK_SRC    3
`define MST_F_SETTLING        2:1
`define MST_F_MODEM_RST_N     0
`define MST_F_SYMBOL_RATE     6:4
`define MST_F_LINE_CODE       3:2
`define MST_F_CRYSTAL_RANGE   1:0
`define MST_F_RX_MATCH        7:4
`define MST_F_TX_MATCH        3:0
`define MST_F_SYNTH_RST_N     0
`define MST_F_PRE_SWING       7:6
`define MST_F_PRE_CURRENT     5:4
`define MST_F_IF_INPUT        3
`define MST_F_IF_FRONT        2
`define MST_F_PROBE_ONE       7
`define MST_F_PROBE_TWO       6
`define MST_F_PUMP_FORCE      5
`define MST_F_PUMP_FORCE_VAL  4:0
`define MST_F_PUMP_BLOCK      5
`define MST_F_OSC_FORCE       4
`define MST_F_OSC_FORCE_VAL   3:0
`define MST_F_LOOP_BW         5:0
`define MST_F_LOOP_OPEN       4
`define MST_F_DAC_FORCE_VAL   3:0

// Lock pin source code that carries the violation flag
`define MST_LOCK_SEL_VIOLATION 4'h9

// Settling time in baud per settling code
`define MST_SETTLE_0  7'd11
`define MST_SETTLE_1  7'd22
`define MST_SETTLE_2  7'd43
`define MST_SETTLE_3  7'd86

// Samples per half Manchester bit; a perfect bit grades 14
`define MST_HALF_BIT_SAMPLES 7

`endif

// [rtl/mst_pkg.sv]
package mst_pkg;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } mst_cfg_req_type;

  typedef struct packed {
    logic [4:0] pump_current;
    logic [3:0] cal_dac;
    logic [3:0] osc_array;
  } mst_cal_type;

  typedef enum logic [1:0] {
    MST_LC_NRZ,
    MST_LC_MANCHESTER,
    MST_LC_UART,
    MST_LC_UNUSED
  } mst_line_code_type;

endpackage

// [rtl/mst_man_grader.sv]
`timescale 1ns/1ps
`include "mst_consts.svh"

module mst_man_grader #(
  parameter int HALF = `MST_HALF_BIT_SAMPLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_sample_valid,
  input  wire logic       i_sample,
  input  wire logic       i_bit_start,
  output logic            o_grade_valid,
  output logic [3:0]      o_grade
);

  logic [3:0] pos_reg;
  logic [2:0] first_reg;
  logic [2:0] second_reg;
  logic [3:0] pos_now;
  logic [2:0] first_now;
  logic [2:0] second_now;
  logic [2:0] diff;

  always_comb begin
    pos_now    = i_bit_start ? 4'h0 : pos_reg;
    first_now  = i_bit_start ? 3'h0 : first_reg;
    second_now = i_bit_start ? 3'h0 : second_reg;
    if (pos_now < 4'(HALF)) begin
      first_now = first_now + 3'(i_sample);
    end else begin
      second_now = second_now + 3'(i_sample);
    end
    diff = (first_now > second_now) ? first_now - second_now
                                    : second_now - first_now;
  end

  // Counters restart on every bit boundary so a slipped bit cannot smear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_reg    <= 4'h0;
      first_reg  <= 3'h0;
      second_reg <= 3'h0;
    end else if (i_sample_valid) begin
      if (pos_now == 4'(2 * HALF - 1)) begin
        pos_reg    <= 4'h0;
        first_reg  <= 3'h0;
        second_reg <= 3'h0;
      end else begin
        pos_reg    <= pos_now + 4'h1;
        first_reg  <= first_now;
        second_reg <= second_now;
      end
    end
  end

  // Balanced halves give 14, a constant level gives 0
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_grade_valid <= 1'b0;
      o_grade       <= 4'h0;
    end else begin
      o_grade_valid <= i_sample_valid && (pos_now == 4'(2 * HALF - 1));
      if (i_sample_valid && (pos_now == 4'(2 * HALF - 1))) begin
        o_grade <= {diff, 1'b0};
      end
    end
  end

endmodule

// [rtl/mst_reg_bank.sv]
`timescale 1ns/1ps
`include "mst_consts.svh"
// Behaviour
// - Violation flag when grade below nonzero limit
// - Grade bits fourteen balanced, zero constant
// - Manual lock bit locks averaging filter
// - Lock source selects automatic or manual lock
// - Settling code selects 11/22/43/86 baud
// - Active-low modem soft reset, resets high
// - Symbol-rate field selects baud rate
// - Line-code field selects NRZ/Manchester/UART
// - Crystal-range field selects crystal band
// - Active-low synthesiser soft reset, resets high
// - Pump force applies forced pump current
// - Oscillator force applies forced array value
// - Probe bits route test points, else ground
// - Pulse block suppresses up and down pulses
// - Loop open enables forced calibration DAC
// - Readbacks report applied pump, DAC, array
// - IF input and front-amp pin routing
// - Lock select 1001 drives violation flag
// - Global reset low reloads all defaults

module mst_reg_bank (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_global_rst_b,
  input  wire mst_pkg::mst_cfg_req_type   i_cfg,
  output logic [7:0]                      o_cfg_rdata,
  input  wire logic                       i_sample_valid,
  input  wire logic                       i_sample,
  input  wire logic                       i_bit_start,
  input  wire logic                       i_avg_auto_lock,
  input  wire logic [3:0]                 i_lock_select,
  input  wire mst_pkg::mst_cal_type       i_cal,
  input  wire logic                       i_pump_up,
  input  wire logic                       i_pump_dn,
  output logic                            o_violation_flag,
  output logic                            o_lock_pin,
  output logic                            o_avg_lock,
  output logic [6:0]                      o_settle_baud,
  output logic                            o_modem_rst_b,
  output logic [2:0]                      o_symbol_rate_sel,
  output mst_pkg::mst_line_code_type      o_line_code,
  output logic [1:0]                      o_crystal_range_sel,
  output logic [3:0]                      o_rx_match,
  output logic [3:0]                      o_tx_match,
  output logic                            o_synth_rst_b,
  output logic [1:0]                      o_pre_swing,
  output logic [1:0]                      o_pre_current,
  output logic                            o_if_input,
  output logic                            o_if_front,
  output logic                            o_loop_probe_one,
  output logic                            o_loop_probe_two,
  output logic                            o_pump_pin_ground,
  output logic [4:0]                      o_applied_pump_current,
  output logic                            o_pump_up,
  output logic                            o_pump_dn,
  output logic [3:0]                      o_applied_osc_array,
  output logic [5:0]                      o_loop_bandwidth_factor,
  output logic                            o_loop_open,
  output logic [3:0]                      o_applied_cal_dac
);

  function automatic logic [3:0] reg_index(input logic [6:0] addr);
    case (addr)
      `MST_OFS_DEMOD_FILTER_CONFIG:        reg_index = `MST_IDX_DFC;
      `MST_OFS_RATE_FORMAT_CRYSTAL_CONFIG: reg_index = `MST_IDX_RFC;
      `MST_OFS_IMPEDANCE_TUNE_CAPS:        reg_index = `MST_IDX_ITC;
      `MST_OFS_SYNTH_RESET_CTRL:           reg_index = `MST_IDX_SRC;
      `MST_OFS_DIVIDER_IF_TEST_CTRL:       reg_index = `MST_IDX_DIT;
      `MST_OFS_PUMP_PROBE_FORCE:           reg_index = `MST_IDX_PPF;
      `MST_OFS_PUMP_BLOCK_OSC_FORCE:       reg_index = `MST_IDX_PBO;
      `MST_OFS_LOOP_BANDWIDTH_SETTING:     reg_index = `MST_IDX_LBS;
      `MST_OFS_LOOP_OPEN_DAC_FORCE:        reg_index = `MST_IDX_LOD;
      default:                             reg_index = `MST_IDX_NONE;
    endcase
  endfunction

  function automatic logic [7:0] reg_default(input logic [3:0] idx);
    case (idx)
      `MST_IDX_DFC: reg_default = `MST_RST_DFC;
      `MST_IDX_RFC: reg_default = `MST_RST_RFC;
      `MST_IDX_ITC: reg_default = `MST_RST_ITC;
      `MST_IDX_SRC: reg_default = `MST_RST_SRC;
      `MST_IDX_DIT: reg_default = `MST_RST_DIT;
      `MST_IDX_PPF: reg_default = `MST_RST_PPF;
      `MST_IDX_PBO: reg_default = `MST_RST_PBO;
      `MST_IDX_LBS: reg_default = `MST_RST_LBS;
      `MST_IDX_LOD: reg_default = `MST_RST_LOD;
      default:      reg_default = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] reg_mask(input logic [3:0] idx);
    case (idx)
      `MST_IDX_DFC: reg_mask = `MST_MSK_DFC;
      `MST_IDX_RFC: reg_mask = `MST_MSK_RFC;
      `MST_IDX_ITC: reg_mask = `MST_MSK_ITC;
      `MST_IDX_SRC: reg_mask = `MST_MSK_SRC;
      `MST_IDX_DIT: reg_mask = `MST_MSK_DIT;
      `MST_IDX_PPF: reg_mask = `MST_MSK_PPF;
      `MST_IDX_PBO: reg_mask = `MST_MSK_PBO;
      `MST_IDX_LBS: reg_mask = `MST_MSK_LBS;
      `MST_IDX_LOD: reg_mask = `MST_MSK_LOD;
      default:      reg_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [6:0] settle_baud(input logic [1:0] code);
    case (code)
      2'h0:    settle_baud = `MST_SETTLE_0;
      2'h1:    settle_baud = `MST_SETTLE_1;
      2'h2:    settle_baud = `MST_SETTLE_2;
      default: settle_baud = `MST_SETTLE_3;
    endcase
  endfunction

  logic [7:0] cfg_reg [0:`MST_NUM_RW-1];
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic       grade_valid;
  logic [3:0] grade;
  logic [7:0] dfc;
  logic [7:0] rfc;
  logic [7:0] itc;
  logic [7:0] src;
  logic [7:0] dit;
  logic [7:0] ppf;
  logic [7:0] pbo;
  logic [7:0] lbs;
  logic [7:0] lod;

  assign wr_idx = reg_index(i_cfg.addr);
  assign rd_idx = reg_index(i_cfg.addr);
  assign dfc    = cfg_reg[`MST_IDX_DFC];
  assign rfc    = cfg_reg[`MST_IDX_RFC];
  assign itc    = cfg_reg[`MST_IDX_ITC];
  assign src    = cfg_reg[`MST_IDX_SRC];
  assign dit    = cfg_reg[`MST_IDX_DIT];
  assign ppf    = cfg_reg[`MST_IDX_PPF];
  assign pbo    = cfg_reg[`MST_IDX_PBO];
  assign lbs    = cfg_reg[`MST_IDX_LBS];
  assign lod    = cfg_reg[`MST_IDX_LOD];

  // Register storage; the global soft reset wins over a same-cycle write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < `MST_NUM_RW; i++) begin
        cfg_reg[i] <= reg_default(4'(i));
      end
    end else if (!i_global_rst_b) begin
      for (int i = 0; i < `MST_NUM_RW; i++) begin
        cfg_reg[i] <= reg_default(4'(i));
      end
    end else if (i_cfg.we && (wr_idx != `MST_IDX_NONE)) begin
      // Readback offsets decode to no index, so writes there are dropped
      cfg_reg[wr_idx] <= i_cfg.wdata & reg_mask(wr_idx);
    end
  end

  // Read port; data is registered and holds until the next read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata <= 8'h00;
    end else if (i_cfg.re) begin
      if (rd_idx != `MST_IDX_NONE) begin
        o_cfg_rdata <= cfg_reg[rd_idx];
      end else begin
        case (i_cfg.addr)
          `MST_OFS_PUMP_CURRENT_READBACK:
            o_cfg_rdata <= {3'h0, o_applied_pump_current};
          `MST_OFS_TUNE_DAC_READBACK:
            o_cfg_rdata <= {4'h0, o_applied_cal_dac};
          `MST_OFS_OSC_ARRAY_READBACK:
            o_cfg_rdata <= {4'h0, o_applied_osc_array};
          default:
            o_cfg_rdata <= 8'h00;
        endcase
      end
    end
  end

  mst_man_grader u_grader (
    .i_clk          (i_clk),
    .i_rst_b        (i_rst_b),
    .i_sample_valid (i_sample_valid),
    .i_sample       (i_sample),
    .i_bit_start    (i_bit_start),
    .o_grade_valid  (grade_valid),
    .o_grade        (grade)
  );

  // With a nonzero limit the flag is re-evaluated once per graded bit and holds between bits; a zero limit clears it at once
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_violation_flag <= 1'b0;
    end else if (dfc[`MST_F_VIOL_LIMIT] == 3'h0) begin
      o_violation_flag <= 1'b0;
    end else if (grade_valid) begin
      o_violation_flag <= ({1'b0, dfc[`MST_F_VIOL_LIMIT]} > grade);
    end
  end

  // Other lock pin sources live outside this bank and read low here
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lock_pin <= 1'b0;
    end else begin
      o_lock_pin <= (i_lock_select == `MST_LOCK_SEL_VIOLATION) &&
                    o_violation_flag;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avg_lock <= 1'b0;
    end else if (dfc[`MST_F_AVG_LOCK_SRC]) begin
      o_avg_lock <= dfc[`MST_F_AVG_LOCK_CTRL];
    end else begin
      o_avg_lock <= i_avg_auto_lock;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_settle_baud <= `MST_SETTLE_3;
    end else begin
      o_settle_baud <= settle_baud(dfc[`MST_F_SETTLING]);
    end
  end

  // Soft resets also assert while the global reset is held low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_modem_rst_b <= 1'b0;
      o_synth_rst_b <= 1'b0;
    end else begin
      o_modem_rst_b <= dfc[`MST_F_MODEM_RST_N] && i_global_rst_b;
      o_synth_rst_b <= src[`MST_F_SYNTH_RST_N] && i_global_rst_b;
    end
  end

  // Unused rate and line codes are passed on as stored
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_symbol_rate_sel   <= 3'h2;
      o_line_code         <= mst_pkg::MST_LC_MANCHESTER;
      o_crystal_range_sel <= 2'h0;
    end else begin
      o_symbol_rate_sel   <= rfc[`MST_F_SYMBOL_RATE];
      o_line_code         <= mst_pkg::mst_line_code_type'(
                               rfc[`MST_F_LINE_CODE]);
      o_crystal_range_sel <= rfc[`MST_F_CRYSTAL_RANGE];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_match <= 4'h0;
      o_tx_match <= 4'h0;
    end else begin
      o_rx_match <= itc[`MST_F_RX_MATCH];
      o_tx_match <= itc[`MST_F_TX_MATCH];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pre_swing   <= 2'h0;
      o_pre_current <= 2'h0;
      o_if_input    <= 1'b0;
      o_if_front    <= 1'b0;
    end else begin
      o_pre_swing   <= dit[`MST_F_PRE_SWING];
      o_pre_current <= dit[`MST_F_PRE_CURRENT];
      o_if_input    <= dit[`MST_F_IF_INPUT];
      o_if_front    <= dit[`MST_F_IF_FRONT];
    end
  end

  // Pin is grounded only when no test point is routed to it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_loop_probe_one  <= 1'b0;
      o_loop_probe_two  <= 1'b0;
      o_pump_pin_ground <= 1'b1;
    end else begin
      o_loop_probe_one  <= ppf[`MST_F_PROBE_ONE];
      o_loop_probe_two  <= ppf[`MST_F_PROBE_TWO];
      o_pump_pin_ground <= !(ppf[`MST_F_PROBE_ONE] ||
                             ppf[`MST_F_PROBE_TWO]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_applied_pump_current <= 5'h10;
    end else if (ppf[`MST_F_PUMP_FORCE]) begin
      o_applied_pump_current <= ppf[`MST_F_PUMP_FORCE_VAL];
    end else begin
      o_applied_pump_current <= i_cal.pump_current;
    end
  end

  // Pulses cost one cycle of latency in exchange for a clean register edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pump_up <= 1'b0;
      o_pump_dn <= 1'b0;
    end else begin
      o_pump_up <= i_pump_up && !pbo[`MST_F_PUMP_BLOCK];
      o_pump_dn <= i_pump_dn && !pbo[`MST_F_PUMP_BLOCK];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_applied_osc_array <= 4'h8;
    end else if (pbo[`MST_F_OSC_FORCE]) begin
      o_applied_osc_array <= pbo[`MST_F_OSC_FORCE_VAL];
    end else begin
      o_applied_osc_array <= i_cal.osc_array;
    end
  end

  // The host owns the fast-rate value; hardware only carries it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_loop_bandwidth_factor <= 6'h25;
    end else begin
      o_loop_bandwidth_factor <= lbs[`MST_F_LOOP_BW];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_loop_open <= 1'b0;
    end else begin
      o_loop_open <= lod[`MST_F_LOOP_OPEN];
    end
  end

  // Forced DAC value is ignored while the loop is closed
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_applied_cal_dac <= 4'h0;
    end else if (lod[`MST_F_LOOP_OPEN]) begin
      o_applied_cal_dac <= lod[`MST_F_DAC_FORCE_VAL];
    end else begin
      o_applied_cal_dac <= i_cal.cal_dac;
    end
  end

endmodule

// [testbench/mst_reg_bank_chk.sv]
`timescale 1ns/1ps
module mst_reg_bank_chk (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_global_rst_b,
  input  wire mst_pkg::mst_cfg_req_type i_cfg,
  input  wire logic [7:0]               o_cfg_rdata,
  input  wire logic [3:0]               i_lock_select,
  input  wire logic                     i_pump_up,
  input  wire logic                     i_pump_dn,
  input  wire logic                     o_violation_flag,
  input  wire logic                     o_lock_pin,
  input  wire logic                     o_modem_rst_b,
  input  wire logic                     o_synth_rst_b,
  input  wire logic                     o_loop_probe_one,
  input  wire logic                     o_loop_probe_two,
  input  wire logic                     o_pump_pin_ground,
  input  wire logic [4:0]               o_applied_pump_current,
  input  wire logic                     o_pump_up,
  input  wire logic                     o_pump_dn,
  input  wire logic [3:0]               o_applied_osc_array,
  input  wire logic                     o_loop_open,
  input  wire logic [3:0]               o_applied_cal_dac
);
  logic                                 wok;
  // Writes during global reset are lost, so they trigger nothing
  assign wok = i_cfg.we && i_global_rst_b;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_pump_force;
    wok && i_cfg.addr == 7'h40 && i_cfg.wdata[5] |->
      ##2 o_applied_pump_current == $past(i_cfg.wdata[4:0], 2);
  endproperty
  a_pump_force: assert property (p_pump_force)
    else $error("pump force");
  property p_osc_force;
    wok && i_cfg.addr == 7'h41 && i_cfg.wdata[4] |->
      ##2 o_applied_osc_array == $past(i_cfg.wdata[3:0], 2);
  endproperty
  a_osc_force: assert property (p_osc_force)
    else $error("osc force");
  property p_dac_force;
    wok && i_cfg.addr == 7'h43 && i_cfg.wdata[4] |->
      ##2 o_loop_open && o_applied_cal_dac == $past(i_cfg.wdata[3:0], 2);
  endproperty
  a_dac_force: assert property (p_dac_force)
    else $error("dac force");
  property p_block;
    wok && i_cfg.addr == 7'h41 && i_cfg.wdata[5] |->
      ##2 !o_pump_up && !o_pump_dn;
  endproperty
  a_block: assert property (p_block) else $error("pulse block");
  property p_pulse_cause;
    (o_pump_up |-> $past(i_pump_up)) and (o_pump_dn |-> $past(i_pump_dn));
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("pulse");
  property p_limit_off;
    wok && i_cfg.addr == 7'h10 && i_cfg.wdata[7:5] == 3'h0 |->
      ##2 !o_violation_flag;
  endproperty
  a_limit_off: assert property (p_limit_off)
    else $error("limit off");
  property p_lock_pin;
    o_lock_pin == ($past(i_lock_select) == 4'h9 && $past(o_violation_flag));
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("lock pin");
  property p_glob;
    !i_global_rst_b |=> !o_modem_rst_b && !o_synth_rst_b;
  endproperty
  a_glob: assert property (p_glob) else $error("global reset");
  property p_ground;
    o_pump_pin_ground == !(o_loop_probe_one || o_loop_probe_two);
  endproperty
  a_ground: assert property (p_ground) else $error("pin ground");
  property p_rd_pump;
    i_cfg.re && i_cfg.addr == 7'h44 |=>
      o_cfg_rdata == {3'h0, $past(o_applied_pump_current)};
  endproperty
  a_rd_pump: assert property (p_rd_pump)
    else $error("pump readback");
  c_force: cover property (wok && i_cfg.addr == 7'h40 && i_cfg.wdata[5]);
  c_flag: cover property (o_violation_flag);
  c_lock: cover property (o_lock_pin);
endmodule
bind mst_reg_bank mst_reg_bank_chk u_mst_reg_bank_chk (.*);

// [testbench/mst_host_model.sv]
`timescale 1ns/1ps
module mst_host_model (
  input  wire logic                     i_clk,
  input  wire logic [7:0]               i_rdata,
  output mst_pkg::mst_cfg_req_type      o_cfg
);
  initial o_cfg = '0;
  // Released lines show inverted values so stale data cannot match
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_cfg = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(negedge i_clk);
    o_cfg = '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_cfg = '{addr: a, wdata: 8'h5a, we: 1'b0, re: 1'b1};
    @(negedge i_clk);
    d = i_rdata;
    o_cfg = '{addr: ~a, wdata: 8'ha5, we: 1'b0, re: 1'b0};
  endtask
  task automatic set_rate(input logic [2:0] r);
    wr(7'h11, {1'b0, r, 4'h4});
    if (r >= 3'h4) wr(7'h42, 8'h3f);
  endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic                      i_clk, i_rst_b, i_global_rst_b, i_bit_start;
  logic                      i_sample_valid, i_sample, i_avg_auto_lock;
  logic                      i_pump_up, i_pump_dn, o_violation_flag;
  logic [3:0]                i_lock_select, o_rx_match, o_tx_match;
  mst_pkg::mst_cfg_req_type  i_cfg;
  mst_pkg::mst_cal_type      i_cal;
  mst_pkg::mst_line_code_type o_line_code;
  logic [7:0]                o_cfg_rdata, rv, sh [9];
  logic                      o_lock_pin, o_avg_lock, o_modem_rst_b;
  logic [6:0]                o_settle_baud;
  logic [2:0]                o_symbol_rate_sel;
  logic [1:0]                o_crystal_range_sel, o_pre_swing, o_pre_current;
  logic                      o_synth_rst_b, o_if_input, o_if_front;
  logic                      o_loop_probe_one, o_loop_probe_two;
  logic                      o_pump_pin_ground, o_pump_up, o_pump_dn;
  logic [4:0]                o_applied_pump_current;
  logic [3:0]                o_applied_osc_array, o_applied_cal_dac;
  logic [5:0]                o_loop_bandwidth_factor;
  logic                      o_loop_open, pu, pd, fl;
  int                        miscompares, samples_checked, a, n;
  int                        seed = 32'h0000_83db;
  logic [6:0] ofs [9] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h1c,
                          7'h40, 7'h41, 7'h42, 7'h43};
  logic [7:0] dft [9] = '{8'h67, 8'h24, 8'h00, 8'h01, 8'h00,
                          8'h10, 8'h08, 8'h25, 8'h04};
  logic [7:0] msk [9] = '{8'hff, 8'h7f, 8'hff, 8'h01, 8'hfc,
                          8'hff, 8'h3f, 8'h3f, 8'h1f};
  logic [6:0] stl [4] = '{7'h0b, 7'h16, 7'h2b, 7'h56};
  logic [11:0] crn [5] = '{12'h53f, 12'h630, 12'h81f, 12'h80f, 12'h5c0};

  mst_reg_bank u_mst_reg_bank (.*);
  mst_host_model u_mst_host_model (.i_clk(i_clk), .i_rdata(o_cfg_rdata),
                                   .o_cfg(i_cfg));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_all;
    logic [4:0] pc;
    logic [3:0] oa, cd;
    pc = sh[5][5] ? sh[5][4:0] : i_cal.pump_current;
    oa = sh[6][4] ? sh[6][3:0] : i_cal.osc_array;
    cd = sh[8][4] ? sh[8][3:0] : i_cal.cal_dac;
    chk({o_settle_baud, o_modem_rst_b},
        {stl[sh[0][2:1]], sh[0][0]});
    chk(o_avg_lock, sh[0][3] ? sh[0][4] : i_avg_auto_lock);
    chk({o_symbol_rate_sel, o_line_code,
         o_crystal_range_sel}, sh[1]);
    chk({o_rx_match, o_tx_match}, sh[2]);
    chk(o_synth_rst_b, sh[3][0]);
    chk({o_pre_swing, o_pre_current, o_if_input, o_if_front},
        sh[4][7:2]);
    chk({o_loop_probe_one, o_loop_probe_two, o_pump_pin_ground},
        {sh[5][7:6], ~|sh[5][7:6]});
    chk(o_applied_pump_current, pc);
    chk(o_applied_osc_array, oa);
    chk(o_loop_bandwidth_factor, sh[7][5:0]);
    chk({o_loop_open, o_applied_cal_dac}, {sh[8][4], cd});
    u_mst_host_model.rd(7'h44, rv);
    chk(rv, {3'h0, pc});
    u_mst_host_model.rd(7'h45, rv);
    chk(rv, {4'h0, cd});
    u_mst_host_model.rd(7'h46, rv);
    chk(rv, {4'h0, oa});
  endtask

  task automatic wr_chk(input int k, input logic [7:0] v);
    u_mst_host_model.wr(ofs[k], v);
    sh[k] = v & msk[k];
    @(negedge i_clk);
    chk_all;
    u_mst_host_model.rd(ofs[k], rv);
    chk(rv, sh[k]);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    give_verdict;
  end

  initial begin
    {i_rst_b, i_bit_start, i_sample_valid, i_sample} = '0;
    {i_pump_up, i_pump_dn, i_avg_auto_lock, i_lock_select} = '0;
    i_global_rst_b = 1'b1;
    i_cal = 13'h05a3;
    sh = dft;
    repeat (5) @(negedge i_clk);
    i_rst_b = 1'b1;
    for (int k = 0; k < 9; k++) begin
      u_mst_host_model.rd(ofs[k], rv);
      chk(rv, dft[k]);
    end
    chk_all;
    for (int k = 0; k < 5; k++) wr_chk(crn[k][11:8], crn[k][7:0]);
    repeat (40) begin
      n = $unsigned($random(seed)) % 9;
      i_cal = $random(seed);
      i_avg_auto_lock = $random(seed);
      wr_chk(n, $random(seed));
    end
    u_mst_host_model.wr(7'h44, 8'hff);
    u_mst_host_model.wr(7'h46, 8'h0f);
    u_mst_host_model.wr(7'h20, 8'hff);
    chk_all;
    u_mst_host_model.rd(7'h14, rv);
    chk(rv, 8'h00);
    for (int lim = 0; lim < 8; lim++) begin
      for (int t = 0; t < 2; t++) begin
        a = t ? $unsigned($random(seed)) % 8 : lim / 2;
        i_lock_select = t ? 4'h9 : 4'($random(seed));
        wr_chk(0, {3'(lim), sh[0][4:0]});
        for (int k = 0; k < 14; k++) begin
          @(negedge i_clk);
          i_sample_valid = 1'b1;
          i_bit_start = (k == 0);
          i_sample = t ? (k >= 14 - a) : (k < a);
        end
        @(negedge i_clk);
        {i_sample_valid, i_bit_start} = 2'b00;
        fl = (lim != 0) && (2 * a < lim);
        @(negedge i_clk);
        chk(o_violation_flag, fl);
        @(negedge i_clk);
        chk(o_lock_pin, fl && i_lock_select == 4'h9);
      end
    end
    for (int b = 0; b < 2; b++) begin
      wr_chk(6, {2'h0, 1'(b), 5'h08});
      for (int k = 0; k < 16; k++) begin
        @(negedge i_clk);
        if (k > 0) chk({o_pump_up, o_pump_dn},
            {pu, pd} & {2{~sh[6][5]}});
        pu = $random(seed);
        pd = $random(seed);
        i_pump_up = pu;
        i_pump_dn = pd;
      end
    end
    u_mst_host_model.set_rate(3'h4);
    sh[1] = 8'h44;
    sh[7] = 8'h3f;
    @(negedge i_clk);
    chk_all;
    i_global_rst_b = 1'b0;
    @(negedge i_clk);
    chk({o_modem_rst_b, o_synth_rst_b}, 2'b00);
    i_global_rst_b = 1'b1;
    sh = dft;
    @(negedge i_clk);
    chk_all;
    give_verdict;
  end
endmodule
